// [psr_pkg.sv]
package psr_pkg;
   localparam int NCH   = 4;
   localparam int NSLOT = 3;
   localparam int NENT  = 12;
   localparam int DW    = 16;

   // register word indices; byte address is four times the index
   localparam logic [5:0] W_CTRL  = 6'h00;
   localparam logic [5:0] W_GSW   = 6'h01;
   localparam logic [5:0] W_CFG0  = 6'h04;
   localparam logic [5:0] W_DATA0 = 6'h10;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [8:0] CFG_RST  = 9'h000;

   // sensor_config_reg fields
   localparam int CF_ASYNC   = 0;
   localparam int CF_RATE    = 1;
   localparam int CF_LEN10   = 2;
   localparam int CF_SLOTDIS = 3;
   localparam int CF_BLK     = 4;
   localparam int CF_FILT    = 5;
   // sensor_channel_control_reg: enables in 3:0, sync pulse enables from here
   localparam int CT_SYNC    = 4;
   // global_status_word fields
   localparam int GS_FLT     = 0;
   localparam int GS_ACT     = 4;
   // sensor_data_reg fields
   localparam int DB_FLT     = 15;
   localparam int DB_INV     = 0;
   localparam int DB_SLOT    = 1;
   localparam int DB_STG     = 2;
   localparam int DB_NODATA  = 3;

   // timing at 125 MHz
   localparam int CLK_MHZ    = 125;
   localparam logic [6:0] TICK_CYC = 7'(CLK_MHZ);
   localparam int BIT_NS_125 = 8000;
   localparam int BIT_NS_189 = 5291;
   localparam logic [11:0] BIT_CYC_125 = 12'(BIT_NS_125 * CLK_MHZ / 1000);
   localparam logic [11:0] BIT_CYC_189 = 12'(BIT_NS_189 * CLK_MHZ / 1000);
   localparam int FILT_STEP_NS = 64;
   localparam logic [6:0] FILT_STEP_CYC = 7'((FILT_STEP_NS * CLK_MHZ + 999) / 1000);
   localparam int WR_DELAY_NS = 1000;
   localparam logic [7:0] WR_DELAY_CYC = 8'((WR_DELAY_NS * CLK_MHZ + 999) / 1000);
   localparam logic [11:0] SYNC_LEN_US  = 12'h014;
   localparam logic [11:0] SYNC_STEP_US = 12'h01e;
   localparam logic [11:0] S1_LO = 12'h028;
   localparam logic [11:0] S1_HI = 12'h08c;
   localparam logic [11:0] S2_LO = 12'h096;
   localparam logic [11:0] S2_HI = 12'h0fa;
   localparam logic [11:0] S3_LO = 12'h104;
   localparam logic [11:0] S3_HI = 12'h168;
endpackage

// [psr_entry_mem.sv]
`timescale 1ns/1ps
module psr_entry_mem (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // write side, one enable per entry, one word per channel
   input  wire logic [11:0] we,
   input  wire logic [63:0] wdata,
   // read side
   input  wire logic [3:0]  raddr,
   output logic      [15:0] rdata
);
   logic [15:0] mem [12];

   // all sixteen bits of an entry load in the same edge, so a word is never torn
   for (genvar i = 0; i < 12; i++) begin : g_ent
      always_ff @(posedge clk) begin
         if (we[i]) begin
            mem[i] <= wdata[(i / 3) * 16 +: 16];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// [psr_sensor_receiver.sv]
// Operation
// (RULE_01) async mode: slot 2 and slot 3 addresses read as all zeros
// (RULE_02) channel turns on only if supply ok at request; stays on after
// (RULE_03) blanking select picks 5 ms or 10 ms current-limit mask per activation
// (RULE_04) slot check disable bit turns off slot timing check for the channel
// (RULE_05) twelve data registers, three independent ones per channel
// (RULE_06) error sets data word msb and codes the errors below it
// (RULE_07) any sensor fault sets the fault summary bit of the status word
// (RULE_08) faults clear only on read, never by disabling the channel
// (RULE_09) reading clears data; reads before new data give an error word
// (RULE_10) 125 or 189 kbps, 8 or 10 data bits, one parity bit
// (RULE_11) bit value taken from direction of mid-bit transition
// (RULE_12) per-channel deglitch filter in 15 steps ahead of decoder
// (RULE_13) data register updated whole after fixed delay past frame end
// (RULE_14) any bit error discards the frame and restarts at minimum bit time; here decoding runs on until 5/4 bit passes with no mid-bit edge
// (RULE_15) invalid flag is or of start, length/stop, parity, bit-window errors
// (RULE_16) sync mode: slot 1, 2, 3 messages go to registers 1, 2, 3
// (RULE_17) sync mode: channel fault written to all three slot registers
// (RULE_18) each rising sync trigger edge emits staggered sync pulses
// (RULE_19) async channels never emit sync pulses
// (RULE_20) slot check on: message ending off-window records slot error
// (RULE_21) two messages ending in one slot: the second one is kept
// (RULE_22) async: three registers are a fifo at slot 1 address, oldest dropped
`timescale 1ns/1ps
module psr_sensor_receiver #(
   parameter int BLANK_SHORT_US = 5000,
   parameter int BLANK_LONG_US  = 10000
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // sensor side
   input  wire logic [3:0]  sense_hi,
   input  wire logic [3:0]  ilim_hit,
   input  wire logic        supply_ok_threshold,
   input  wire logic        sync_trigger_input,
   output logic      [3:0]  sensor_supply_output,
   output logic      [3:0]  sync_pulse
);
   logic [7:0]  ctrl;
   logic [8:0]  cfg [4];
   logic        summary;
   logic [6:0]  div;
   logic        tick;
   logic [11:0] slot_t;
   logic        trig_q;
   logic [1:0]  rd_ph;
   logic [1:0]  rd_kind;
   logic [15:0] rd_val;
   logic [3:0]  raddr;
   logic [11:0] mem_we;
   logic [63:0] mem_wd;
   logic [15:0] mem_rd;
   logic [7:0]  rp_w;
   logic [7:0]  cnt_w;
   logic [11:0] vld_w;
   logic [3:0]  flt_ev;
   logic [3:0]  pop;
   logic [11:0] clr_e;
   logic [3:0]  act_w;

   wire [5:0]  word   = avs_address[7:2];
   wire        take   = avs_read && rd_ph == 2'd0;
   wire        wr     = avs_write && !avs_read;
   wire [15:0] wmask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire        is_dat = word >= psr_pkg::W_DATA0 && word < psr_pkg::W_DATA0 + 6'd12;
   wire [3:0]  ent    = 4'(word - psr_pkg::W_DATA0);
   wire [1:0]  ech    = 2'(ent / 4'd3);
   wire [1:0]  esl    = 2'(ent % 4'd3);
   wire        is_cfg = word >= psr_pkg::W_CFG0 && word < psr_pkg::W_CFG0 + 6'd4;
   wire [1:0]  cch    = 2'(word - psr_pkg::W_CFG0);

   psr_entry_mem u_mem (  // RULE_05
      .clk   (clk),
      .rstn  (rstn),
      .we    (mem_we),
      .wdata (mem_wd),
      .raddr (raddr),
      .rdata (mem_rd)
   );

   // reads take three cycles so that read data always come from flip-flops
   assign avs_waitrequest = avs_read && rd_ph != 2'd2;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_ph <= 2'd0;
      end else if (avs_read) begin
         rd_ph <= (rd_ph == 2'd2) ? 2'd0 : rd_ph + 2'd1;
      end else begin
         rd_ph <= 2'd0;
      end
   end

   // read decode; side effects happen at the edge the request is first seen
   always_comb begin
      raddr = 4'd0;
      pop   = 4'd0;
      clr_e = 12'd0;
      if (take && is_dat) begin
         if (cfg[ech][psr_pkg::CF_ASYNC]) begin
            raddr = 4'(ech * 2'd3 + rp_w[2*ech +: 2]);
            pop[ech] = esl == 2'd0 && cnt_w[2*ech +: 2] != 2'd0;     // RULE_22
         end else begin
            raddr = ent;
            clr_e[ent] = 1'b1;                                      // RULE_09
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_kind <= 2'd0;
         rd_val  <= 16'h0000;
      end else if (take) begin
         rd_val <= 16'h0000;
         if (is_dat) begin
            if (cfg[ech][psr_pkg::CF_ASYNC]) begin
               rd_kind <= esl != 2'd0 ? 2'd3 :                       // RULE_01
                          (cnt_w[2*ech +: 2] != 2'd0 ? 2'd1 : 2'd2);
            end else begin
               rd_kind <= vld_w[ent] ? 2'd1 : 2'd2;                   // RULE_09
            end
         end else begin
            rd_kind <= 2'd0;
            if (word == psr_pkg::W_CTRL) begin
               rd_val <= {8'h00, ctrl};
            end else if (word == psr_pkg::W_GSW) begin
               rd_val <= 16'({act_w, 3'b000, summary});
            end else if (is_cfg) begin
               rd_val <= {7'h00, cfg[cch]};
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_ph == 2'd1) begin
         case (rd_kind)
            2'd0:    avs_readdata <= {16'h0000, rd_val};
            2'd1:    avs_readdata <= {16'h0000, mem_rd};
            2'd2:    avs_readdata <= 32'(16'h8008);
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // register writes complete without wait; unmapped writes are dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= psr_pkg::CTRL_RST;
         for (int i = 0; i < psr_pkg::NCH; i++) begin
            cfg[i] <= psr_pkg::CFG_RST;
         end
      end else if (wr) begin
         if (word == psr_pkg::W_CTRL && avs_byteenable[0]) begin
            ctrl <= avs_writedata[7:0];
         end
         if (is_cfg) begin
            cfg[cch] <= 9'((cfg[cch] & ~wmask) | (avs_writedata[15:0] & wmask));
         end
      end
   end

   // a new fault wins over the clear from a status read in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         summary <= 1'b0;
      end else if (|flt_ev) begin
         summary <= 1'b1;                                              // RULE_07
      end else if (take && word == psr_pkg::W_GSW) begin
         summary <= 1'b0;
      end
   end

   // microsecond tick shared by blanking, slot and sync timing
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div  <= 7'd0;
         tick <= 1'b0;
      end else begin
         tick <= div == psr_pkg::TICK_CYC - 7'd1;
         div  <= (div == psr_pkg::TICK_CYC - 7'd1) ? 7'd0 : div + 7'd1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trig_q <= 1'b0;
         slot_t <= 12'hfff;
      end else begin
         trig_q <= sync_trigger_input;
         if (sync_trigger_input && !trig_q) begin
            slot_t <= 12'd0;                                          // RULE_18
         end else if (tick && slot_t != 12'hfff) begin
            slot_t <= slot_t + 12'd1;
         end
      end
   end

   for (genvar c = 0; c < psr_pkg::NCH; c++) begin : g_ch
      wire        asyn  = cfg[c][psr_pkg::CF_ASYNC];
      wire        len10 = cfg[c][psr_pkg::CF_LEN10];
      wire [3:0]  fsel  = cfg[c][psr_pkg::CF_FILT +: 4];
      wire [6:0]  flim  = 7'(fsel * psr_pkg::FILT_STEP_CYC);
      wire [11:0] tb    = cfg[c][psr_pkg::CF_RATE] ? psr_pkg::BIT_CYC_189 : psr_pkg::BIT_CYC_125;
      wire [11:0] lo    = tb - (tb >> 2);
      wire [11:0] hi    = tb + (tb >> 2);
      logic        flvl;
      logic        fprev;
      logic [6:0]  fcnt;
      logic        busy;
      logic [11:0] t;
      logic [3:0]  nb;
      logic [12:0] sh;
      logic        bnd;
      logic        berr;
      logic        fin;
      logic        fin_ok;
      logic        dpend;
      logic [7:0]  dcnt;
      logic [15:0] dword;
      logic        active;
      logic [13:0] bcnt;
      logic [1:0]  rp;
      logic [1:0]  wp;
      logic [1:0]  cnt;
      logic [2:0]  vld;
      logic [2:0]  we3;
      logic [15:0] wword;
      logic [1:0]  sidx;
      logic        sok;
      logic        spul;
      wire edge_s  = flvl != fprev;
      wire go      = dpend && dcnt == 8'd0;
      wire flt_go  = active && bcnt == 14'd0 && ilim_hit[c];
      wire push    = asyn && (flt_go || go);
      wire discard = push && !pop[c] && cnt == 2'd3;
      wire [3:0] nexp = len10 ? 4'd13 : 4'd11;
      wire st_ok  = len10 ? sh[12:11] == 2'b00 : sh[10:9] == 2'b00;
      wire req_on = wr && word == psr_pkg::W_CTRL && avs_byteenable[0] && avs_writedata[c];
      wire req_of = wr && word == psr_pkg::W_CTRL && avs_byteenable[0] && !avs_writedata[c];

      // a level change must persist for the selected number of steps
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            flvl  <= 1'b0;
            fprev <= 1'b0;
            fcnt  <= 7'd0;
         end else begin
            fprev <= flvl;
            if (sense_hi[c] == flvl) begin
               fcnt <= 7'd0;
            end else if (fcnt >= flim) begin
               flvl <= sense_hi[c];                                    // RULE_12
               fcnt <= 7'd0;
            end else begin
               fcnt <= fcnt + 7'd1;
            end
         end
      end

      // edges inside the 3/4..5/4 bit window are mid-bit; one boundary edge allowed
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            busy   <= 1'b0;
            t      <= 12'd0;
            nb     <= 4'd0;
            sh     <= 13'd0;
            bnd    <= 1'b0;
            berr   <= 1'b0;
            fin    <= 1'b0;
            fin_ok <= 1'b0;
         end else begin
            fin <= 1'b0;
            if (!busy) begin
               if (edge_s && !flvl) begin
                  busy <= 1'b1;
                  t    <= 12'd0;
                  nb   <= 4'd1;
                  sh   <= 13'd0;
                  bnd  <= 1'b0;
                  berr <= 1'b0;
               end
            end else if (t > hi) begin
               busy   <= 1'b0;                                         // RULE_14
               fin    <= 1'b1;
               fin_ok <= !berr && nb == nexp && st_ok && !(^sh);       // RULE_15
            end else begin
               t <= t + 12'd1;
               if (edge_s) begin
                  if (t < lo) begin
                     if (bnd) begin
                        berr <= 1'b1;
                     end
                     bnd <= 1'b1;
                  end else begin
                     sh  <= {sh[11:0], flvl};                          // RULE_11
                     t   <= 12'd0;
                     bnd <= 1'b0;
                     if (nb == 4'd13) begin
                        berr <= 1'b1;
                     end else begin
                        nb <= nb + 4'd1;
                     end
                  end
               end
            end
         end
      end

      // hold the finished word for the write delay, then commit it in one edge
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            dpend <= 1'b0;
            dcnt  <= 8'd0;
            dword <= 16'h0000;
         end else if (fin) begin
            dpend <= 1'b1;                                             // RULE_13
            dcnt  <= psr_pkg::WR_DELAY_CYC;
            if (!fin_ok) begin
               dword <= 16'h8001;                                      // RULE_06
            end else if (len10) begin
               dword <= {6'h00, sh[10:1]};                             // RULE_10
            end else begin
               dword <= {8'h00, sh[8:1]};
            end
         end else if (go) begin
            dpend <= 1'b0;
         end else if (dpend) begin
            dcnt <= dcnt - 8'd1;
         end
      end

      always_comb begin
         sidx = 2'd2;
         sok  = slot_t >= psr_pkg::S3_LO && slot_t <= psr_pkg::S3_HI;
         if (slot_t <= psr_pkg::S1_HI) begin
            sidx = 2'd0;
            sok  = slot_t >= psr_pkg::S1_LO;
         end else if (slot_t <= psr_pkg::S2_HI) begin
            sidx = 2'd1;
            sok  = slot_t >= psr_pkg::S2_LO;
         end
      end

      always_comb begin
         we3   = 3'b000;
         wword = dword;
         if (flt_go) begin
            wword = 16'h8004;
            we3   = asyn ? 3'(3'b001 << wp) : 3'b111;                  // RULE_17
         end else if (go) begin
            if (asyn) begin
               we3 = 3'(3'b001 << wp);                                 // RULE_22
            end else begin
               we3 = 3'(3'b001 << sidx);                               // RULE_16 RULE_21
               if (!sok && !cfg[c][psr_pkg::CF_SLOTDIS]) begin         // RULE_04
                  wword = 16'h8002;                                    // RULE_20
               end
            end
         end
      end

      assign mem_we[3*c +: 3] = we3;
      assign mem_wd[16*c +: 16] = wword;
      assign flt_ev[c] = |we3 && wword[psr_pkg::DB_FLT];
      assign rp_w[2*c +: 2] = rp;
      assign cnt_w[2*c +: 2] = cnt;
      assign vld_w[3*c +: 3] = vld;
      assign act_w[c] = active;

      // fifo pointers wrap at three; a push into a full fifo drops the oldest
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rp  <= 2'd0;
            wp  <= 2'd0;
            cnt <= 2'd0;
         end else if (!asyn) begin
            rp  <= 2'd0;
            wp  <= 2'd0;
            cnt <= 2'd0;
         end else begin
            if (push) begin
               wp <= (wp == 2'd2) ? 2'd0 : wp + 2'd1;
            end
            if (pop[c] || discard) begin
               rp <= (rp == 2'd2) ? 2'd0 : rp + 2'd1;                  // RULE_22
            end
            if (push && !pop[c] && !discard) begin
               cnt <= cnt + 2'd1;
            end else if (pop[c] && !push) begin
               cnt <= cnt - 2'd1;
            end
         end
      end

      // a write in the same cycle as the clearing read keeps the entry valid
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            vld <= 3'b000;
         end else begin
            vld <= (vld & ~clr_e[3*c +: 3]) | we3;                     // RULE_08 RULE_09
         end
      end

      // disabling leaves stored faults in place until they are read
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            active <= 1'b0;
            bcnt   <= 14'd0;
         end else if (req_on && !active) begin
            if (supply_ok_threshold) begin
               active <= 1'b1;                                         // RULE_02
               bcnt   <= cfg[c][psr_pkg::CF_BLK] ? 14'(BLANK_LONG_US)
                                                 : 14'(BLANK_SHORT_US); // RULE_03
            end
         end else if (req_of || flt_go) begin
            active <= 1'b0;
         end else if (tick && bcnt != 14'd0) begin
            bcnt <= bcnt - 14'd1;                                      // RULE_03
         end
      end

      always_comb begin
         spul = slot_t >= 12'(c) * psr_pkg::SYNC_STEP_US &&
                slot_t < 12'(c) * psr_pkg::SYNC_STEP_US + psr_pkg::SYNC_LEN_US;
      end

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            sync_pulse[c] <= 1'b0;
         end else begin
            sync_pulse[c] <= spul && active && ctrl[psr_pkg::CT_SYNC + c] && !asyn; // RULE_18 RULE_19
         end
      end

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            sensor_supply_output[c] <= 1'b0;
         end else begin
            sensor_supply_output[c] <= active;
         end
      end
   end
endmodule

// [psr_sensor_receiver_sva.sv]
`timescale 1ns/1ps
module psr_sensor_receiver_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // sensor side
   input wire logic [3:0]  ilim_hit,
   input wire logic        supply_ok_threshold,
   input wire logic [3:0]  sensor_supply_output,
   input wire logic [3:0]  sync_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // stalled read cycles; a wrap past two is itself a failure
   logic [1:0] wait_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_cnt <= 2'h0;
      end else if (avs_read && avs_waitrequest) begin
         wait_cnt <= wait_cnt + 2'h1;
      end else begin
         wait_cnt <= 2'h0;
      end
   end
   AST_WR_NO_WAIT: assert property (avs_write && !avs_read |-> !avs_waitrequest)
      else $error("write stalled");
   AST_IDLE_NO_WAIT: assert property (!avs_read |-> !avs_waitrequest)
      else $error("stall without read");
   AST_RD_STALL_MAX: assert property (wait_cnt <= 2'h2)
      else $error("read stalled too long");
   AST_RD_ANSWER: assert property ($rose(avs_read) |-> avs_waitrequest [*2] ##1 !avs_waitrequest)
      else $error("read answer late or early");
   AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
      else $error("read data moved outside an answer");
   AST_SYNC_ONEHOT: assert property ($onehot0(sync_pulse))
      else $error("sync pulses overlap");
   AST_SUPPLY_ON: assert property (|(sensor_supply_output & ~$past(sensor_supply_output))
      |-> $past(avs_write, 2) && $past(supply_ok_threshold, 2))
      else $error("channel on without request and supply");
   AST_SUPPLY_OFF: assert property (|($past(sensor_supply_output) & ~sensor_supply_output)
      |-> $past(avs_write, 2) || |$past(ilim_hit, 2))
      else $error("channel dropped without cause");
endmodule

bind psr_sensor_receiver psr_sensor_receiver_sva u_sva (
   .clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ilim_hit(ilim_hit),
   .supply_ok_threshold(supply_ok_threshold), .sensor_supply_output(sensor_supply_output),
   .sync_pulse(sync_pulse)
);

// [psr_sensor_model.sv]
`timescale 1ns/1ps
module psr_sensor_model (
   // clock
   input wire logic   clk,
   // comparator level per channel, idle low between frames
   output logic [3:0] sense_hi
);
   // half of a 189 kbps bit; 660 cycles sits inside the decoder window
   localparam int HALF = 330;
   initial sense_hi = 4'h0;
   task automatic send(input int ch, input logic [7:0] data, input logic bad);
      logic [10:0] bits;
      bits = {2'b00, data, ^data ^ bad};
      for (int i = 10; i >= 0; i--) begin
         @(posedge clk);
         sense_hi[ch] <= !bits[i];
         repeat (HALF) @(posedge clk);
         sense_hi[ch] <= bits[i];
         repeat (HALF - 1) @(posedge clk);
      end
      @(posedge clk);
      sense_hi[ch] <= 1'b0;
      // idle gap covers frame end plus the register write delay
      repeat (6 * HALF) @(posedge clk);
   endtask
endmodule

// [psr_sensor_receiver_tb_top.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module psr_sensor_receiver_tb_top;
   typedef struct {
      logic        sup;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] data;
   } psr_row_t;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [3:0]  sense_hi;
   logic [3:0]  ilim_hit = 4'h0;
   logic        sup_ok = 1'b0;
   logic        trig = 1'b0;
   logic [3:0]  supply_out;
   logic [3:0]  sync_pulse;
   logic [31:0] rd;
   int          fails = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          cnt0;
   int          cnt1;
   psr_row_t    rows [11] = '{
      '{1'b0, 1'b0, 8'h00, 32'h00},
      '{1'b0, 1'b0, 8'h04, 32'h00},
      '{1'b0, 1'b0, 8'h10, 32'h00},
      '{1'b0, 1'b0, 8'hfc, 32'h00},
      '{1'b0, 1'b1, 8'h00, 32'h01},
      '{1'b0, 1'b0, 8'h04, 32'h00},
      '{1'b1, 1'b1, 8'h00, 32'h01},
      '{1'b1, 1'b0, 8'h04, 32'h10},
      '{1'b0, 1'b0, 8'h04, 32'h10},
      '{1'b0, 1'b1, 8'h10, 32'h03},
      '{1'b0, 1'b0, 8'h10, 32'h03}
   };

   always #4 clk = ~clk;

   psr_sensor_receiver #(.BLANK_SHORT_US(5), .BLANK_LONG_US(10)) dut (
      .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sense_hi(sense_hi),
      .ilim_hit(ilim_hit), .supply_ok_threshold(sup_ok), .sync_trigger_input(trig),
      .sensor_supply_output(supply_out), .sync_pulse(sync_pulse)
   );
   psr_sensor_model sen (.clk(clk), .sense_hi(sense_hi));

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // only the cycle ceiling below ends a wait that never finishes
      do begin
         @(posedge clk);
      end while (avs_waitrequest);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      `CHK(rd, exp)
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         sup_ok <= rows[i].sup;
         bus(rows[i].wr, rows[i].addr, rows[i].data);
         if (!rows[i].wr) `CHK(rd, rows[i].data)
      end
      // bad parity, then the channel is switched off before the fault is read
      sen.send(0, 8'h5a, 1'b1);
      bus(1'b1, 8'h00, 32'h0);
      chk(8'h04, 32'h01);
      chk(8'h04, 32'h00);
      chk(8'h40, 32'h8001);
      sup_ok <= 1'b1;
      bus(1'b1, 8'h00, 32'h1);
      // four arrivals into a three-deep queue
      for (int i = 1; i <= 4; i++) sen.send(0, 8'(8'ha0 + i), 1'b0);
      for (int i = 2; i <= 4; i++) chk(8'h40, 32'h0a0 + 32'(i));
      chk(8'h40, 32'h8008);
      chk(8'h44, 32'h0);
      chk(8'h48, 32'h0);
      // sync mode before any trigger: the slot timer is parked past every window
      bus(1'b1, 8'h14, 32'h02);
      sen.send(1, 8'h3c, 1'b0);
      chk(8'h54, 32'h8002);
      bus(1'b1, 8'h14, 32'h0a);
      sen.send(1, 8'h3c, 1'b0);
      chk(8'h54, 32'h3c);
      chk(8'h54, 32'h8008);
      // sync pulses asked on ch0 (async) and ch1 (sync)
      bus(1'b1, 8'h00, 32'h33);
      trig <= 1'b1;
      cnt0 = 0;
      cnt1 = 0;
      repeat (10000) begin
         @(posedge clk);
         cnt0 += int'(sync_pulse[0] === 1'b1);
         cnt1 += int'(sync_pulse[1] === 1'b1);
      end
      trig <= 1'b0;
      `CHK(cnt0, 0)
      `CHK(cnt1, 2500)
      // current limit on ch2 with both masking lengths
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, 8'h18, 32'(b) << 4);
         bus(1'b1, 8'h00, 32'h37);
         ilim_hit <= 4'h4;
         repeat (450 * (b + 1)) @(posedge clk);
         `CHK(supply_out[2], 1'b1)
         repeat (1050 * (b + 1)) @(posedge clk);
         `CHK(supply_out[2], 1'b0)
         ilim_hit <= 4'h0;
         for (int s = 6; s < 9; s++) chk(8'(8'h40 + 4 * s), 32'h8004);
      end
      // reset in mid-run drops the active channels
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(supply_out, 4'h0)
      rstn <= 1'b1;
      chk(8'h04, 32'h0);
      wrap_up();
   end
endmodule
